// *** src/dma_channel_mapping_config.v ***
// Operation
// - Capability bits 14-12 read 3h: 128 descriptor sets.
// - Capability bits 10-8 read 4h: 32 interrupt channels.
// - Capability bits 6-4 read 4h: eight quick channels.
// - Capability bits 2-0 read 5h: 32 DMA channels.
// - Map bits 13-5 hold set index; software writes only 0-7Fh.
// - Map bits 4-2 pick the trigger word of the set.
// - Writing a channel's trigger word raises that quick-channel event.
// - Maps reset to set 0 with slot 0.
// - Each of 32 channels has a queue-select field.
// - Queue selects reset to zero, so events go to queue 0.
// - Queue 0 feeds mover 0, queue 1 feeds mover 1.
// - Select 0 is queue 0, 1h is queue 1, others reserved.
// - Capability bits 18-16 read 2h: two queues and movers.
`timescale 1ns/100ps
`include "dma_map_regs.vh"

module dma_channel_mapping_config
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // DMA channel synchronisation events
   input wire [31:0] sync_event,
   // Quick-channel events, one-cycle pulses
   output reg [7:0] quick_event,
   // Move orders to the mover units
   output wire [31:0] mover0_order,
   output wire [31:0] mover1_order
);

   // Byte-lane merge of write data into an old value
   function [31:0] merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer b;
      begin
         merge = old_val;
         for (b = 0; b < 4; b = b + 1)
         begin
            if (strb[b])
            begin
               merge[b*8 +: 8] = new_val[b*8 +: 8];
            end
         end
      end
   endfunction

   // Word-aligned address match
   function match;
      input [15:0] addr;
      input [15:0] base;
      input [3:0] low_bits;
      reg [15:0] keep;
      begin
         keep = 16'hFFFF << low_bits;
         match = ((addr & keep) == (base & keep));
      end
   endfunction

   // Capability code fields, each placed at its own position
   localparam [31:0] CAP_EVQ = {29'h0, `CAP_EVQ_CODE} << `CAP_EVQ_LSB;
   localparam [31:0] CAP_SET = {29'h0, `CAP_SET_CODE} << `CAP_SET_LSB;
   localparam [31:0] CAP_INT = {29'h0, `CAP_INT_CODE} << `CAP_INT_LSB;
   localparam [31:0] CAP_QCH = {29'h0, `CAP_QCH_CODE} << `CAP_QCH_LSB;
   localparam [31:0] CAP_DCH = {29'h0, `CAP_DCH_CODE} << `CAP_DCH_LSB;
   // Bits outside the five code fields read zero
   localparam [31:0] CAP_VALUE =
      CAP_EVQ |
      CAP_SET |
      CAP_INT |
      CAP_QCH |
      CAP_DCH;

   // Low address bits ignored by each decoder
   localparam [3:0] CAP_SPAN = 4'h2;
   localparam [3:0] QMAP_SPAN = 4'h5;
   localparam [3:0] QSEL_SPAN = 4'h4;
   localparam [3:0] EVSTAT_SPAN = 4'h2;

   integer i;

   reg [31:0] qmap_reg [0:7];
   reg [31:0] qsel_reg [0:3];
   reg [7:0] evstat_reg;
   reg [7:0] evstat_next;
   reg [31:0] desc_mem [0:1023];

   reg [31:0] rd_value;
   reg rd_mapped;

   wire setup_phase;
   wire access_phase;
   wire wr_commit;
   wire hit_cap;
   wire hit_qmap;
   wire hit_qsel;
   wire hit_evstat;
   wire hit_desc;
   wire mapped;
   wire [2:0] qmap_idx;
   wire [1:0] qsel_idx;
   wire [9:0] desc_idx;
   wire [7:0] trig_hit;
   wire [95:0] map_flat;
   wire [127:0] qsel_flat;
   // Per-target write enables and descriptor address fields
   wire wr_qmap;
   wire wr_qsel;
   wire wr_evclr;
   wire wr_desc;
   wire [6:0] desc_set;
   wire [2:0] desc_slot;

   assign setup_phase = psel & ~penable;
   assign access_phase = psel & penable;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_commit = access_phase & pwrite & pready;

   // Address decode
   assign hit_cap = match(paddr, `CAP_OFFSET, CAP_SPAN);
   assign hit_qmap = match(paddr, `QMAP_BASE, QMAP_SPAN);
   assign hit_qsel = match(paddr, `QSEL_BASE, QSEL_SPAN);
   assign hit_evstat = match(paddr, `EVSTAT_OFFSET, EVSTAT_SPAN);
   assign hit_desc = (paddr[15:12] == `DESC_PAGE);
   assign mapped = hit_cap | hit_qmap | hit_qsel | hit_evstat | hit_desc;

   assign qmap_idx = paddr[4:2];
   assign qsel_idx = paddr[3:2];
   assign desc_idx = paddr[11:2];
   // Descriptor window: set index and word within the set
   assign desc_set = paddr[11:5];
   assign desc_slot = paddr[4:2];

   // Unmapped addresses answer with an error and have no effect
   assign pslverr = access_phase & ~mapped;

   // Write enables, one per target
   assign wr_qmap = wr_commit & hit_qmap;
   assign wr_qsel = wr_commit & hit_qsel;
   assign wr_evclr = wr_commit & hit_evstat & pstrb[0];
   assign wr_desc = wr_commit & hit_desc;

   // Quick-channel maps, packed as {set index, slot}
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : pack_map
         assign map_flat[g*12 +: 12] = qmap_reg[g][`QMAP_SET_MSB:`QMAP_SLOT_LSB];
      end
      for (g = 0; g < 4; g = g + 1)
      begin : pack_qsel
         assign qsel_flat[g*32 +: 32] = qsel_reg[g];
      end
   endgenerate

   // Trigger-word detection on committed descriptor writes
   quick_trigger_match trig
   (
      .wr_commit(wr_desc),
      .set_idx(desc_set),
      .word_idx(desc_slot),
      .map_flat(map_flat),
      .hit(trig_hit)
   );

   // Channel events routed to queues and their movers
   queue_router router
   (
      .pclk(pclk),
      .presetn(presetn),
      .sync_event(sync_event),
      .qsel_flat(qsel_flat),
      .mover0_order(mover0_order),
      .mover1_order(mover1_order)
   );

   // Read mux, sampled at the setup edge so data is ready in the access cycle
   always @*
   begin
      rd_value = 32'h00000000;
      rd_mapped = 1'b1;
      if (hit_cap)
      begin
         rd_value = CAP_VALUE;
      end
      else if (hit_qmap)
      begin
         rd_value = qmap_reg[qmap_idx] & `QMAP_MASK;
      end
      else if (hit_qsel)
      begin
         rd_value = qsel_reg[qsel_idx] & `QSEL_MASK;
      end
      else if (hit_evstat)
      begin
         rd_value = {24'h000000, evstat_reg};
      end
      else if (hit_desc)
      begin
         rd_value = desc_mem[desc_idx];
      end
      else
      begin
         // Unmapped: read data is zero and the access answers with an error
         rd_mapped = 1'b0;
      end
   end

   // Sticky quick-event status, write one to clear; a new event wins
   always @*
   begin
      evstat_next = evstat_reg;
      if (wr_evclr)
      begin
         evstat_next = evstat_next & ~pwdata[7:0];
      end
      evstat_next = evstat_next | trig_hit;
   end

   // Register bank
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (i = 0; i < `QMAP_COUNT; i = i + 1)
         begin
            qmap_reg[i] <= `QMAP_RESET;
         end
         for (i = 0; i < `QSEL_COUNT; i = i + 1)
         begin
            qsel_reg[i] <= `QSEL_RESET;
         end
         evstat_reg <= `EVSTAT_RESET;
      end
      else
      begin
         if (wr_qmap)
         begin
            // Set index and slot writable; reserved bits stay zero
            qmap_reg[qmap_idx] <= merge(qmap_reg[qmap_idx], pwdata, pstrb) & `QMAP_MASK;
         end
         if (wr_qsel)
         begin
            // Field bits writable; the bit above each field stays zero
            qsel_reg[qsel_idx] <= merge(qsel_reg[qsel_idx], pwdata, pstrb) & `QSEL_MASK;
         end
         evstat_reg <= evstat_next;
      end
   end

   // Descriptor set memory, no reset
   always @(posedge pclk)
   begin
      if (wr_desc)
      begin
         desc_mem[desc_idx] <= merge(desc_mem[desc_idx], pwdata, pstrb);
      end
   end

   // Read data, loaded at the setup edge of a read and held until the next
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
      end
      else if (setup_phase && !pwrite)
      begin
         prdata <= rd_mapped ? rd_value : 32'h00000000;
      end
   end

   // One pulse per trigger-word write, the cycle after commit
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         quick_event <= 8'h00;
      end
      else
      begin
         quick_event <= trig_hit;
      end
   end

endmodule

// *** src/dma_map_regs.vh ***
`ifndef DMA_MAP_REGS_VH
`define DMA_MAP_REGS_VH

// Byte offsets of the register bank
`define CAP_OFFSET 16'h0004
`define QMAP_BASE 16'h0200
`define QSEL_BASE 16'h0240
`define EVSTAT_OFFSET 16'h0260
`define DESC_PAGE 4'h4

// Counts
`define QMAP_COUNT 8
`define QSEL_COUNT 4
`define DESC_WORDS 1024

// Capability fields
`define CAP_EVQ_LSB 16
`define CAP_EVQ_CODE 3'h2
`define CAP_SET_LSB 12
`define CAP_SET_CODE 3'h3
`define CAP_INT_LSB 8
`define CAP_INT_CODE 3'h4
`define CAP_QCH_LSB 4
`define CAP_QCH_CODE 3'h4
`define CAP_DCH_LSB 0
`define CAP_DCH_CODE 3'h5

// Quick-channel map fields
`define QMAP_SET_LSB 5
`define QMAP_SET_MSB 13
`define QMAP_SLOT_LSB 2
`define QMAP_SLOT_MSB 4
`define QMAP_MASK 32'h00003FFC
`define QMAP_RESET 32'h00000000

// Queue-select fields
`define QSEL_FIELD_W 3
`define QSEL_STRIDE 4
`define QSEL_MASK 32'h77777777
`define QSEL_RESET 32'h00000000
`define QSEL_QUEUE0 3'h0
`define QSEL_QUEUE1 3'h1

// Event status
`define EVSTAT_MASK 32'h000000FF
`define EVSTAT_RESET 8'h00

`endif

// *** src/quick_trigger_match.v ***
`timescale 1ns/100ps
`include "dma_map_regs.vh"

module quick_trigger_match
(
   // Committed descriptor write
   input wire wr_commit,
   input wire [6:0] set_idx,
   input wire [2:0] word_idx,
   // Packed maps: {set index, slot} per quick channel
   input wire [95:0] map_flat,
   // Match per quick channel
   output reg [7:0] hit
);

   integer i;

   always @*
   begin
      hit = 8'h00;
      for (i = 0; i < `QMAP_COUNT; i = i + 1)
      begin
         // Reserved set indices from 80h never match a real set
         if (wr_commit && map_flat[i*12+3 +: 9] == {2'b00, set_idx} && map_flat[i*12 +: 3] == word_idx)
         begin
            hit[i] = 1'b1;
         end
      end
   end

endmodule

// *** src/queue_router.v ***
`timescale 1ns/100ps
`include "dma_map_regs.vh"

module queue_router
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Channel events and selections
   input wire [31:0] sync_event,
   input wire [127:0] qsel_flat,
   // Move orders per mover unit
   output reg [31:0] mover0_order,
   output reg [31:0] mover1_order
);

   integer k;
   reg [31:0] m0_next;
   reg [31:0] m1_next;
   reg [2:0] sel;

   always @*
   begin
      m0_next = 32'h00000000;
      m1_next = 32'h00000000;
      sel = 3'h0;
      for (k = 0; k < 32; k = k + 1)
      begin
         sel = qsel_flat[k*`QSEL_STRIDE +: `QSEL_FIELD_W];
         // Queue n always feeds mover unit n
         if (sel == `QSEL_QUEUE0)
         begin
            m0_next[k] = sync_event[k];
         end
         else if (sel == `QSEL_QUEUE1)
         begin
            m1_next[k] = sync_event[k];
         end
         // Reserved selections drop the event
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mover0_order <= 32'h00000000;
         mover1_order <= 32'h00000000;
      end
      else
      begin
         mover0_order <= m0_next;
         mover1_order <= m1_next;
      end
   end

endmodule

// *** dv/dma_channel_mapping_config_asserts.sv ***
`timescale 1ns/100ps
module dma_map_checker
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] prdata,
   // Events
   input wire [31:0] sync_event,
   input wire [7:0] quick_event,
   input wire [31:0] mover0_order,
   input wire [31:0] mover1_order
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd_setup = psel && !penable && !pwrite;
   wire wr_desc = psel && penable && pwrite && paddr[15:12] == 4'h4;
   AST_CAP: assert property (rd_setup && paddr == 16'h0004 |=> prdata == 32'h00023445)
      else $error("capability value wrong");
   AST_QMAP_RSVD: assert property (rd_setup && paddr[15:5] == 11'h010 |=> prdata[31:14] == 18'h0 && prdata[1:0] == 2'h0)
      else $error("map reserved bits set");
   AST_QSEL_RSVD: assert property (rd_setup && paddr[15:4] == 12'h024 |=> (prdata & 32'h88888888) == 32'h0)
      else $error("queue select reserved bits set");
   AST_ROUTE: assert property (((mover0_order | mover1_order) & ~$past(sync_event)) == 32'h0)
      else $error("move order without event");
   AST_EXCL: assert property ((mover0_order & mover1_order) == 32'h0)
      else $error("event sent to both movers");
   AST_PULSE: assert property (quick_event != 8'h00 |=> quick_event == 8'h00)
      else $error("quick event longer than a cycle");
   AST_CAUSE: assert property (quick_event != 8'h00 |-> $past(wr_desc))
      else $error("quick event without descriptor write");
   AST_NO_EVT: assert property (psel && penable && pwrite && !wr_desc |=> quick_event == 8'h00)
      else $error("quick event from register write");
endmodule

bind dma_channel_mapping_config dma_map_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .sync_event(sync_event),
   .quick_event(quick_event), .mover0_order(mover0_order), .mover1_order(mover1_order));

// *** dv/dma_channel_mapping_config_bench.sv ***
`timescale 1ns/100ps
module dma_channel_mapping_config_bench;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [15:0] paddr = 16'h0000;
   reg [31:0] pwdata = 32'h0;
   reg [31:0] sync_event = 32'h0;
   reg drv = 1'b0;
   reg drv_d = 1'b0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire [7:0] quick_event;
   wire [31:0] mover0_order;
   wire [31:0] mover1_order;
   logic [32:0] rd_q[$];
   logic [7:0] ev_q[$];
   logic [63:0] mv_q[$];
   logic [31:0] qsel[4] = '{default: 32'h0};
   logic [2:0] slot[8];
   int err_total = 0;
   int n_compared = 0;
   always #4 pclk = ~pclk;
   dma_channel_mapping_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_event(sync_event), .quick_event(quick_event), .mover0_order(mover0_order),
      .mover1_order(mover1_order));
   task final_report;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task note(input string w, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (e !== g)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask
   task chk_rd(input logic [32:0] e, input logic [32:0] g);
      note("read", {31'h0, e}, {31'h0, g});
   endtask
   task chk_ev(input logic [7:0] e, input logic [7:0] g);
      note("quick_event", {56'h0, e}, {56'h0, g});
   endtask
   task chk_mv(input logic [63:0] e, input logic [63:0] g);
      note("mover_orders", e, g);
   endtask
   // Results are matched to the oldest expectation as they appear
   always @(posedge pclk)
   begin
      drv_d <= drv;
      if (psel && penable && pready && !pwrite)
         chk_rd(rd_q.pop_front(), {pslverr, prdata});
      if (presetn && quick_event !== 8'h00)
         chk_ev(ev_q.pop_front(), quick_event);
      if (drv_d)
         chk_mv(mv_q.pop_front(), {mover1_order, mover0_order});
   end
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16)
      begin
         err_total++;
         final_report;
      end
   endtask
   task rd(input int a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, 16'(a), 32'h0);
   endtask
   task route(input int cycles);
      logic [31:0] r;
      logic [63:0] e;
      logic [2:0] s;
      for (int c = 0; c < cycles; c++)
      begin
         @(posedge pclk);
         r = $urandom;
         for (int k = 0; k < 32; k++)
         begin
            s = qsel[k / 8][4 * (k % 8) +: 3];
            e[k] = r[k] && s == 3'h0;
            e[32 + k] = r[k] && s == 3'h1;
         end
         mv_q.push_back(e);
         sync_event <= r;
         drv <= 1'b1;
      end
      @(posedge pclk);
      drv <= 1'b0;
      sync_event <= 32'h0;
   endtask
   initial
   begin
      logic [31:0] r;
      void'($urandom(76));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(32'h0004, 33'h000023445);
      for (int n = 0; n < 8; n++)
         rd(32'h0200 + 4 * n, 33'h0);
      for (int n = 0; n < 4; n++)
         rd(32'h0240 + 4 * n, 33'h0);
      route(8);
      ev_q.push_back(8'hFF);
      apb(1'b1, 16'h4000, 32'h1);
      $display("test reset values done");
      apb(1'b1, 16'h0004, 32'hFFFFFFFF);
      rd(32'h0004, 33'h000023445);
      rd(32'h0100, 33'h100000000);
      $display("test read-only and unmapped done");
      for (int n = 0; n < 8; n++)
      begin
         r = $urandom & 32'hFFFFDFFF;
         apb(1'b1, 16'(32'h0200 + 4 * n), r);
         rd(32'h0200 + 4 * n, {1'b0, r & 32'h00003FFC});
      end
      $display("test map fields done");
      for (int n = 0; n < 8; n++)
      begin
         slot[n] = 3'($urandom);
         apb(1'b1, 16'(32'h0200 + 4 * n), {18'h0, 9'(n + 1), slot[n], 2'h0});
      end
      for (int n = 0; n < 8; n++)
      begin
         ev_q.push_back(8'h01 << n);
         apb(1'b1, 16'(32'h4000 + 32 * (n + 1) + 4 * slot[n]), $urandom);
         apb(1'b1, 16'(32'h4000 + 32 * (n + 1) + 4 * (slot[n] ^ 3'h1)), $urandom);
      end
      rd(32'h0260, {1'b0, 32'h000000FF});
      apb(1'b1, 16'h0260, 32'h0000000F);
      rd(32'h0260, {1'b0, 32'h000000F0});
      $display("test quick events done");
      qsel[0] = 32'h98109801;
      for (int n = 1; n < 4; n++)
         qsel[n] = $urandom & 32'h99999999;
      for (int n = 0; n < 4; n++)
      begin
         apb(1'b1, 16'(32'h0240 + 4 * n), qsel[n]);
         qsel[n] = qsel[n] & 32'h77777777;
         rd(32'h0240 + 4 * n, {1'b0, qsel[n]});
      end
      route(24);
      $display("test queue routing done");
      repeat (2) @(posedge pclk);
      note("leftover", 64'h0, 64'(rd_q.size() + ev_q.size() + mv_q.size()));
      final_report;
   end
endmodule
